// [swc_sleep_ctrl.sv]
// Top of the sleep and wake controller with its APB register file.
`timescale 1ns/1ns
module swc_sleep_ctrl (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Core side
  input wire logic i_sleep_exec,
  input wire logic i_clrwdt_exec,
  output logic o_cpu_clk_en,
  output logic o_prefetch_next,
  output logic o_resume,
  output logic o_irq_vector_req,
  // Interrupt sources
  input wire logic [swc_pkg::FLAG_W-1:0] i_flag_event,
  input wire logic i_ext_irq,
  // Reset sources
  input wire swc_pkg::swc_rst_src_t i_rst_src,
  output logic o_device_reset,
  // Watchdog and oscillators
  input wire logic i_wdt_timeout,
  input wire logic i_ost_done,
  output logic o_wdt_clear,
  output logic o_wdt_run,
  output logic o_ost_start,
  output logic o_slow_clks_en,
  // Ports and status
  output logic o_io_hold,
  output logic o_asleep,
  output logic o_power_down_flag_n,
  output logic o_time_out_flag_n
);

  // Watchdog activity for a mode, its software enable and the sleep state
  function automatic logic wdt_active(input logic [1:0] mode, input logic sw_en, input logic asleep);
    logic act;
    act = 1'b0;
    case (mode)
      swc_pkg::WDT_ON: act = 1'b1;
      swc_pkg::WDT_NSLEEP: act = ~asleep;
      swc_pkg::WDT_SW: act = sw_en;
      default: act = 1'b0;
    endcase
    return act;
  endfunction

  swc_pkg::swc_state_t state;
  swc_pkg::swc_state_t next_state;
  logic [swc_pkg::FLAG_W-1:0] enables;
  logic [5:0] control;
  logic pd_n;
  logic to_n;
  logic wdt_wake;
  logic next_pd_n;
  logic next_to_n;
  logic next_wdt_wake;
  wire logic [swc_pkg::FLAG_W-1:0] flags;
  wire logic pending;

  // APB decode
  wire logic setup_phase;
  wire logic wr_access;
  wire logic hit_flags;
  wire logic hit_enables;
  wire logic hit_control;
  wire logic hit_status;
  wire logic hit_any;
  wire logic lane0;
  wire logic wr_flags;
  wire logic wr_enables;
  wire logic wr_control;
  wire logic [31:0] rd_mux;
  wire logic [7:0] status_byte;

  assign setup_phase = i_psel & ~i_penable;
  assign wr_access = i_psel & i_penable & i_pwrite;
  assign hit_flags = (i_paddr == swc_pkg::ADDR_FLAGS);
  assign hit_enables = (i_paddr == swc_pkg::ADDR_ENABLES);
  assign hit_control = (i_paddr == swc_pkg::ADDR_CONTROL);
  assign hit_status = (i_paddr == swc_pkg::ADDR_STATUS);
  assign hit_any = hit_flags | hit_enables | hit_control | hit_status;
  // All fields live in byte lane 0, so only that strobe matters
  assign lane0 = i_pstrb[0];
  assign wr_flags = wr_access & hit_flags & lane0;
  assign wr_enables = wr_access & hit_enables & lane0;
  assign wr_control = wr_access & hit_control & lane0;

  // Status byte as software sees it
  assign status_byte = {2'h0, wdt_wake, to_n, pd_n, 1'b0, o_cpu_clk_en, o_asleep};

  // Read selection; low flag bits and unused upper bits read as zero
  assign rd_mux = hit_flags ? {24'h0, flags, 3'h0} :
                  hit_enables ? {24'h0, enables, 3'h0} :
                  hit_control ? {26'h0, control} :
                  hit_status ? {24'h0, status_byte} : 32'h0;

  // Flag storage with set-wins behaviour
  swc_flag_reg u_flags (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_set(i_flag_event),
    .i_wr(wr_flags),
    .i_wdata(i_pwdata[swc_pkg::FLAG_LSB +: swc_pkg::FLAG_W]),
    .o_flags(flags)
  );

  // Enabled pending interrupt
  swc_wake_detect u_wake (
    .i_flags(flags),
    .i_enables(enables),
    .i_ext_irq(i_ext_irq),
    .i_ext_en(control[swc_pkg::CTL_EXT_EN]),
    .o_pending(pending)
  );

  // Control decode
  wire logic global_irq_enable;
  wire logic [1:0] wdt_mode;
  wire logic sw_wdt_en;
  wire logic ost_en;
  assign global_irq_enable = control[swc_pkg::CTL_GIE];
  assign wdt_mode = control[swc_pkg::CTL_WDT_MODE_LSB +: 2];
  assign sw_wdt_en = control[swc_pkg::CTL_SW_WDT_EN];
  assign ost_en = control[swc_pkg::CTL_OST_EN];

  // Event decode
  wire logic master_reset_pin_hit;
  wire logic bor_hit;
  wire logic pin_reset;
  wire logic wdt_on_awake;
  wire logic wdt_on_asleep;
  wire logic wdt_reset;
  wire logic sleeping;
  wire logic sleep_taken;
  wire logic sleep_nop;
  wire logic wdt_wake_evt;
  wire logic irq_wake_evt;
  wire logic wake_evt;
  wire logic hold_clear;

  // Reset sources other than the watchdog ignore the sleep state
  assign master_reset_pin_hit = i_rst_src.master_reset_pin & i_rst_src.master_reset_pin_en;
  assign bor_hit = i_rst_src.bor & i_rst_src.bor_en;
  assign pin_reset = master_reset_pin_hit | bor_hit | i_rst_src.por;
  assign sleeping = (state == swc_pkg::SWC_ASLEEP);
  assign wdt_on_awake = wdt_active(wdt_mode, sw_wdt_en, 1'b0);
  assign wdt_on_asleep = wdt_active(wdt_mode, sw_wdt_en, 1'b1);
  // Watchdog resets only while awake; asleep it wakes instead
  assign wdt_reset = i_wdt_timeout & wdt_on_awake & (state == swc_pkg::SWC_AWAKE);
  // Sleep is only entered through the instruction
  assign sleep_taken = (state == swc_pkg::SWC_AWAKE) & i_sleep_exec & ~pending;
  // A source pending before the instruction turns it into a no-op
  assign sleep_nop = (state == swc_pkg::SWC_AWAKE) & i_sleep_exec & pending;
  assign wdt_wake_evt = sleeping & i_wdt_timeout & wdt_on_asleep;
  assign irq_wake_evt = sleeping & pending;
  assign wake_evt = wdt_wake_evt | irq_wake_evt;
  // Watchdog kept clear while the start-up timer runs
  assign hold_clear = (state == swc_pkg::SWC_OST_WAIT);

  // Next values of the registered core and watchdog outputs
  wire logic clr_instr;
  wire logic in_resume;
  wire logic next_cpu_clk_en;
  wire logic next_io_hold;
  wire logic next_wdt_clear;
  wire logic next_wdt_run;
  // The clear instruction only counts while the core is running
  assign clr_instr = i_clrwdt_exec & (state == swc_pkg::SWC_AWAKE);
  // A reset source in the resume cycle cancels the resume
  assign in_resume = (state == swc_pkg::SWC_RESUME) & ~pin_reset;
  // Clock stays off from entry until resume or a reset
  assign next_cpu_clk_en = (next_state == swc_pkg::SWC_AWAKE) | (next_state == swc_pkg::SWC_RESUME);
  // Port drivers freeze from entry to resume
  assign next_io_hold = (next_state != swc_pkg::SWC_AWAKE);
  // Cleared on entry, on any wake, by the clear instruction and while held
  assign next_wdt_clear = sleep_taken | wake_evt | pin_reset | wdt_reset | hold_clear | clr_instr;
  // Counting in sleep depends on the mode; a no-op sleep leaves it running
  assign next_wdt_run = (next_state == swc_pkg::SWC_ASLEEP) ? wdt_on_asleep :
                        ((next_state == swc_pkg::SWC_OST_WAIT) ? 1'b0 : wdt_on_awake);

  // Sequencer next state
  always_comb begin
    next_state = state;
    case (state)
      swc_pkg::SWC_AWAKE: begin
        if (sleep_taken) begin
          next_state = swc_pkg::SWC_ENTER;
        end
      end
      // Sleep completes even if a source rises now; wake follows next cycle
      swc_pkg::SWC_ENTER: next_state = swc_pkg::SWC_ASLEEP;
      swc_pkg::SWC_ASLEEP: begin
        if (wake_evt) begin
          next_state = ost_en ? swc_pkg::SWC_OST_WAIT : swc_pkg::SWC_RESUME;
        end
      end
      swc_pkg::SWC_OST_WAIT: begin
        if (i_ost_done) begin
          next_state = swc_pkg::SWC_RESUME;
        end
      end
      swc_pkg::SWC_RESUME: next_state = swc_pkg::SWC_AWAKE;
      default: next_state = swc_pkg::SWC_AWAKE;
    endcase
    if (pin_reset) begin
      next_state = swc_pkg::SWC_AWAKE;
    end
  end

  // Power-down and time-out flags
  always_comb begin
    next_pd_n = pd_n;
    next_to_n = to_n;
    next_wdt_wake = wdt_wake;
    if (i_rst_src.por) begin
      next_pd_n = swc_pkg::PD_N_RESET;
      next_to_n = swc_pkg::TO_N_RESET;
      next_wdt_wake = 1'b0;
    end else if (pin_reset) begin
      next_wdt_wake = 1'b0;
    end else if (wdt_reset) begin
      next_to_n = 1'b0;
      next_pd_n = 1'b1;
    end else if (sleep_taken) begin
      next_pd_n = 1'b0;
      next_to_n = 1'b1;
      next_wdt_wake = 1'b0;
    end else if (wdt_wake_evt & ~irq_wake_evt) begin
      // Power-down stays clear, time-out drops to mark the wake cause
      next_to_n = 1'b0;
      next_wdt_wake = 1'b1;
    end else if (clr_instr) begin
      next_pd_n = 1'b1;
      next_to_n = 1'b1;
    end
  end

  // Sequencer and flag registers
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      state <= swc_pkg::SWC_AWAKE;
      pd_n <= swc_pkg::PD_N_RESET;
      to_n <= swc_pkg::TO_N_RESET;
      wdt_wake <= 1'b0;
    end else begin
      state <= next_state;
      pd_n <= next_pd_n;
      to_n <= next_to_n;
      wdt_wake <= next_wdt_wake;
    end
  end

  // Software-written enables and control
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      enables <= swc_pkg::ENABLES_RESET;
      control <= swc_pkg::CONTROL_RESET;
    end else begin
      if (wr_enables) begin
        enables <= i_pwdata[swc_pkg::FLAG_LSB +: swc_pkg::FLAG_W];
      end
      if (wr_control) begin
        control <= i_pwdata[5:0];
      end
    end
  end

  // APB answer is prepared in the setup cycle so data is ready with pready
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_prdata <= 32'h0;
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
    end else begin
      o_pready <= 1'b1;
      if (setup_phase) begin
        o_prdata <= i_pwrite ? 32'h0 : rd_mux;
        o_pslverr <= ~hit_any;
      end
    end
  end

  // Core and clock outputs
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_cpu_clk_en <= 1'b1;
      o_prefetch_next <= 1'b0;
      o_resume <= 1'b0;
      o_irq_vector_req <= 1'b0;
      o_device_reset <= 1'b0;
      o_asleep <= 1'b0;
      o_io_hold <= 1'b0;
      o_slow_clks_en <= 1'b1;
    end else begin
      o_cpu_clk_en <= next_cpu_clk_en;
      // Next instruction fetched while the sleep instruction executes
      o_prefetch_next <= sleep_taken | sleep_nop;
      // Resume runs the prefetched instruction first
      o_resume <= in_resume;
      // Service routine only when global enable is set and a source waits
      o_irq_vector_req <= in_resume & global_irq_enable & pending;
      o_device_reset <= pin_reset | wdt_reset;
      o_asleep <= (next_state == swc_pkg::SWC_ASLEEP);
      o_io_hold <= next_io_hold;
      // Low-frequency, Timer1, sensing and converter clocks never stop here
      o_slow_clks_en <= 1'b1;
    end
  end

  // Watchdog control outputs
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_wdt_clear <= 1'b1;
      o_wdt_run <= 1'b0;
      o_ost_start <= 1'b0;
    end else begin
      o_wdt_clear <= next_wdt_clear;
      o_wdt_run <= next_wdt_run;
      o_ost_start <= (next_state == swc_pkg::SWC_OST_WAIT) & sleeping;
    end
  end

  // Published flags
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_power_down_flag_n <= swc_pkg::PD_N_RESET;
      o_time_out_flag_n <= swc_pkg::TO_N_RESET;
    end else begin
      o_power_down_flag_n <= next_pd_n;
      o_time_out_flag_n <= next_to_n;
    end
  end

endmodule

// [swc_pkg.sv]
// Package of constants, types and register map for the sleep and wake controller.
// Notes on behaviour
// - Flags set on event regardless of enables
// - Flag bits 7..3 pending high, reset zero
// - Flag bits 2..0 always read zero
// - Only sleep instruction enters power-down
// - Clear watchdog on entry; runs if allowed
// - Entry clears power-down, sets time-out flag
// - CPU clock stops; slow oscillators keep running
// - I/O ports hold their drive state
// - Non-watchdog resets act same when asleep
// - Resets, watchdog, interrupts wake the device
// - Next instruction prefetched during sleep instruction
// - Individual enable needed; global enable ignored
// - Run next instruction, then service if enabled
// - Watchdog cleared on every wake-up
// - Pending before sleep makes it a no-op
// - Pending during sleep: enter, wake at once
// - Watchdog timeout in sleep wakes, no reset
// - Watchdog held clear until start-up timer done
package swc_pkg;

  // Register byte addresses on the APB
  localparam logic [7:0] ADDR_FLAGS = 8'h00;
  localparam logic [7:0] ADDR_ENABLES = 8'h04;
  localparam logic [7:0] ADDR_CONTROL = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;

  // Flag and enable field: five implemented bits at 7..3
  localparam int FLAG_LSB = 3;
  localparam int FLAG_W = 5;
  localparam logic [FLAG_W-1:0] FLAGS_RESET = 5'h00;
  localparam logic [FLAG_W-1:0] ENABLES_RESET = 5'h00;

  // Control field positions
  localparam int CTL_GIE = 0;
  localparam int CTL_EXT_EN = 1;
  localparam int CTL_WDT_MODE_LSB = 2;
  localparam int CTL_SW_WDT_EN = 4;
  localparam int CTL_OST_EN = 5;
  localparam logic [5:0] CONTROL_RESET = 6'h00;

  // Status field positions
  localparam int ST_ASLEEP = 0;
  localparam int ST_CPU_CLK = 1;
  localparam int ST_PD_N = 3;
  localparam int ST_TO_N = 4;
  localparam int ST_WDT_WAKE = 5;
  localparam logic PD_N_RESET = 1'b1;
  localparam logic TO_N_RESET = 1'b1;

  // Watchdog operating modes
  localparam logic [1:0] WDT_OFF = 2'h0;
  localparam logic [1:0] WDT_SW = 2'h1;
  localparam logic [1:0] WDT_NSLEEP = 2'h2;
  localparam logic [1:0] WDT_ON = 2'h3;

  typedef enum logic [2:0] {
    SWC_AWAKE,
    SWC_ENTER,
    SWC_ASLEEP,
    SWC_OST_WAIT,
    SWC_RESUME
  } swc_state_t;

  // Reset sources as one bundle
  typedef struct packed {
    logic por;
    logic bor;
    logic bor_en;
    logic master_reset_pin;
    logic master_reset_pin_en;
  } swc_rst_src_t;

endpackage

// [swc_flag_reg.sv]
// Peripheral flag register with hardware set that wins over software write.
`timescale 1ns/1ns
module swc_flag_reg (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // Hardware events and software write
  input wire logic [swc_pkg::FLAG_W-1:0] i_set,
  input wire logic i_wr,
  input wire logic [swc_pkg::FLAG_W-1:0] i_wdata,
  // Stored flags
  output logic [swc_pkg::FLAG_W-1:0] o_flags
);

  logic [swc_pkg::FLAG_W-1:0] next_flags;

  // An event in the write cycle survives the write
  assign next_flags = (i_wr ? i_wdata : o_flags) | i_set;

  // Flags reset to not pending
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_flags <= swc_pkg::FLAGS_RESET;
    end else begin
      o_flags <= next_flags;
    end
  end

endmodule

// [swc_wake_detect.sv]
// Pending-interrupt detection that feeds the wake and no-op decisions.
`timescale 1ns/1ns
module swc_wake_detect (
  // Peripheral flags and their enables
  input wire logic [swc_pkg::FLAG_W-1:0] i_flags,
  input wire logic [swc_pkg::FLAG_W-1:0] i_enables,
  // External interrupt
  input wire logic i_ext_irq,
  input wire logic i_ext_en,
  // Result
  output logic o_pending
);

  wire logic periph_pending;

  // Only individually enabled sources count; global enable is not looked at
  assign periph_pending = |(i_flags & i_enables);
  assign o_pending = periph_pending | (i_ext_irq & i_ext_en);

endmodule

// [swc_sleep_ctrl_asserts.sv]
// Checker for sleep entry, wake and flag read behaviour of the sleep controller.
`timescale 1ns/1ns
module swc_sleep_ctrl_asserts (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // Inputs watched
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic i_sleep_exec,
  input wire logic i_wdt_timeout,
  input wire swc_pkg::swc_rst_src_t i_rst_src,
  // Outputs watched
  input wire logic [31:0] o_prdata,
  input wire logic o_cpu_clk_en,
  input wire logic o_prefetch_next,
  input wire logic o_resume,
  input wire logic o_irq_vector_req,
  input wire logic o_device_reset,
  input wire logic o_wdt_clear,
  input wire logic o_wdt_run,
  input wire logic o_ost_start,
  input wire logic o_slow_clks_en,
  input wire logic o_io_hold,
  input wire logic o_asleep,
  input wire logic o_power_down_flag_n,
  input wire logic o_time_out_flag_n
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  // Any reset source that is allowed to act
  wire logic any_src = i_rst_src.por | (i_rst_src.bor & i_rst_src.bor_en) | (i_rst_src.master_reset_pin & i_rst_src.master_reset_pin_en);
  // Unimplemented flag bits never leak onto the bus
  a_flag_low_zero: assert property (
    i_psel && i_penable && !i_pwrite && i_paddr == swc_pkg::ADDR_FLAGS |-> o_prdata[2:0] == 3'h0)
    else $error("flag low bits not zero");
  // Entry shows the status update, watchdog clear and prefetch together
  a_entry_status: assert property (
    $fell(o_cpu_clk_en) |-> !o_power_down_flag_n && o_time_out_flag_n && o_wdt_clear && o_io_hold && o_prefetch_next)
    else $error("entry outputs wrong");
  // Depth two covers either registering choice of the entry path
  a_entry_cause: assert property (
    $fell(o_cpu_clk_en) |-> $past(i_sleep_exec) || $past(i_sleep_exec, 2))
    else $error("sleep entered without instruction");
  a_prefetch_cause: assert property (
    o_prefetch_next |-> $past(i_sleep_exec) || $past(i_sleep_exec, 2))
    else $error("prefetch without sleep");
  a_asleep_clocks: assert property (
    o_asleep |-> !o_cpu_clk_en && o_io_hold && o_slow_clks_en)
    else $error("clocks or ports wrong asleep");
  a_vector_resume: assert property (
    o_irq_vector_req |-> o_resume)
    else $error("vector request without resume");
  a_por_reset: assert property (
    i_rst_src.por |=> o_device_reset)
    else $error("power-on reset not passed on");
  a_wdt_no_reset: assert property (
    o_asleep && i_wdt_timeout && !any_src |=> !o_device_reset)
    else $error("watchdog reset while asleep");
  a_ost_hold: assert property (
    o_ost_start |-> o_wdt_clear && !o_wdt_run && !o_cpu_clk_en)
    else $error("watchdog not held in start-up wait");
  a_wake_clear: assert property (
    $fell(o_asleep) |-> o_wdt_clear)
    else $error("watchdog not cleared on wake");
endmodule

// [test_swc_sleep_ctrl.sv]
// Self-checking testbench of the sleep and wake controller.
`timescale 1ns/1ns
module test_swc_sleep_ctrl;
  logic i_core_clk, i_rst, i_psel, i_penable, i_pwrite, i_sleep_exec, i_clrwdt_exec, i_ext_irq;
  logic i_wdt_timeout, i_ost_done;
  logic [7:0] i_paddr;
  logic [31:0] i_pwdata, o_prdata;
  logic [4:0] i_flag_event;
  swc_pkg::swc_rst_src_t i_rst_src;
  logic o_pready, o_pslverr, o_cpu_clk_en, o_prefetch_next, o_resume, o_irq_vector_req, o_device_reset;
  logic o_wdt_clear, o_wdt_run, o_ost_start, o_slow_clks_en, o_io_hold, o_asleep;
  logic o_power_down_flag_n, o_time_out_flag_n;
  logic [32:0] exp_q[$], msk_q[$], e, m;
  int fails, n_checks, seed, i;
  logic [31:0] d;
  swc_sleep_ctrl u_swc_sleep_ctrl (.i_core_clk, .i_rst, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
    .i_pstrb(4'hF), .o_prdata, .o_pready, .o_pslverr, .i_sleep_exec, .i_clrwdt_exec, .o_cpu_clk_en,
    .o_prefetch_next, .o_resume, .o_irq_vector_req, .i_flag_event, .i_ext_irq, .i_rst_src, .o_device_reset,
    .i_wdt_timeout, .i_ost_done, .o_wdt_clear, .o_wdt_run, .o_ost_start, .o_slow_clks_en, .o_io_hold,
    .o_asleep, .o_power_down_flag_n, .o_time_out_flag_n);
  task check(input logic [32:0] s, input logic [32:0] x);
    n_checks++;
    if (s !== x) begin
      fails++;
      $display("wrong value at %0t: saw %h expected %h", $time, s, x);
    end
  endtask
  task chk1(input logic s, input logic x);
    check({32'h0, s}, {32'h0, x});
  endtask
  task give_verdict;
    // A read whose note was never consumed never completed
    if (exp_q.size() != 0) fails++;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // One APB transfer; zero wait states are not assumed, only the runaway guard ends a stuck wait
  task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge i_core_clk);
    i_psel <= 1'b1; i_penable <= 1'b0; i_pwrite <= w; i_paddr <= a; i_pwdata <= wd;
    @(posedge i_core_clk);
    i_penable <= 1'b1;
    do begin
      @(posedge i_core_clk);
    end while (o_pready !== 1'b1);
    i_psel <= 1'b0; i_penable <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [32:0] mk, input logic [32:0] x);
    exp_q.push_back(x);
    msk_q.push_back(mk);
    apb(1'b0, a, 32'h0);
  endtask
  function logic pick(input int w);
    case (w)
      0: pick = o_asleep;
      1: pick = o_resume;
      2: pick = o_prefetch_next;
      3: pick = o_ost_start;
      default: pick = o_device_reset;
    endcase
  endfunction
  // Bounded wait on a completion output
  task wait_sig(input int w);
    int k;
    k = 0;
    while (pick(w) !== 1'b1 && k < 40) begin
      @(posedge i_core_clk);
      k++;
    end
    if (k >= 40) begin
      fails++;
      $display("wrong value at %0t: wait %0d expired", $time, w);
    end
  endtask
  task pulse_sleep;
    @(posedge i_core_clk) i_sleep_exec <= 1'b1;
    @(posedge i_core_clk) i_sleep_exec <= 1'b0;
  endtask
  task ev(input logic [4:0] b);
    @(posedge i_core_clk) i_flag_event <= b;
    @(posedge i_core_clk) i_flag_event <= 5'h00;
  endtask
  // Read monitor: each completed read is matched with the oldest note
  always @(posedge i_core_clk) begin
    if (i_psel && i_penable && !i_pwrite && o_pready) begin
      if (exp_q.size() == 0) begin
        fails++;
        $display("wrong value at %0t: read without note", $time);
      end else begin
        e = exp_q.pop_front();
        m = msk_q.pop_front();
        check({o_pslverr, o_prdata} & m, e);
      end
    end
  end
  initial begin
    i_core_clk = 1'b0;
    forever #2 i_core_clk = ~i_core_clk;
  end
  // Runaway guard, far beyond the few hundred cycles the tests need
  initial begin
    #200000;
    fails++;
    give_verdict;
  end
  initial begin
    {i_psel, i_penable, i_pwrite, i_sleep_exec, i_clrwdt_exec, i_ext_irq, i_wdt_timeout, i_ost_done} = 8'h00;
    i_paddr = 8'h00; i_pwdata = 32'h0; i_flag_event = 5'h00; i_rst_src = '0; fails = 0; n_checks = 0;
    seed = 30500; i_rst = 1'b1;
    repeat (10) @(posedge i_core_clk);
    i_rst <= 1'b0;
    // Reset values, then an unmapped read that must be refused
    rd(swc_pkg::ADDR_FLAGS, 33'h0FF, 33'h000);
    rd(swc_pkg::ADDR_STATUS, 33'h01B, 33'h01A);
    rd(8'h40, 33'h1FFFFFFFF, 33'h100000000);
    // Each event sets its own flag with every enable off
    for (i = 0; i < 5; i++) begin
      ev(5'h01 << i);
      rd(swc_pkg::ADDR_FLAGS, 33'h0FF, 33'h008 << i);
      apb(1'b1, swc_pkg::ADDR_FLAGS, 32'h0);
    end
    // Random writes never show in the unimplemented bits
    repeat (4) begin
      d = $random(seed);
      apb(1'b1, swc_pkg::ADDR_FLAGS, d);
      rd(swc_pkg::ADDR_FLAGS, 33'h0FF, {25'h0, d[7:3], 3'h0});
    end
    apb(1'b1, swc_pkg::ADDR_FLAGS, 32'h0);
    // Clean entry; a flag without enable must not wake
    pulse_sleep;
    wait_sig(0);
    chk1(o_power_down_flag_n, 1'b0);
    chk1(o_time_out_flag_n, 1'b1);
    chk1(o_wdt_run, 1'b0);
    ev(5'h01);
    repeat (4) @(posedge i_core_clk);
    chk1(o_asleep, 1'b1);
    apb(1'b1, swc_pkg::ADDR_ENABLES, 32'h08);
    wait_sig(1);
    chk1(o_irq_vector_req, 1'b0);
    chk1(o_cpu_clk_en, 1'b1);
    rd(swc_pkg::ADDR_STATUS, 33'h018, 33'h010);
    // Pending before sleep: a no-op that leaves flags and watchdog alone
    @(posedge i_core_clk) i_clrwdt_exec <= 1'b1;
    @(posedge i_core_clk) i_clrwdt_exec <= 1'b0;
    repeat (2) @(posedge i_core_clk);
    pulse_sleep;
    wait_sig(2);
    chk1(o_wdt_clear, 1'b0);
    repeat (3) @(posedge i_core_clk);
    chk1(o_asleep, 1'b0);
    rd(swc_pkg::ADDR_STATUS, 33'h019, 33'h018);
    // External wake through the start-up wait with global enable set
    apb(1'b1, swc_pkg::ADDR_FLAGS, 32'h0);
    apb(1'b1, swc_pkg::ADDR_ENABLES, 32'h0);
    apb(1'b1, swc_pkg::ADDR_CONTROL, 32'h23);
    pulse_sleep;
    wait_sig(0);
    @(posedge i_core_clk) i_ext_irq <= 1'b1;
    wait_sig(3);
    repeat (5) @(posedge i_core_clk);
    chk1(o_wdt_clear, 1'b1);
    chk1(o_cpu_clk_en, 1'b0);
    @(posedge i_core_clk) i_ost_done <= 1'b1;
    @(posedge i_core_clk) i_ost_done <= 1'b0;
    wait_sig(1);
    chk1(o_irq_vector_req, 1'b1);
    @(posedge i_core_clk) i_ext_irq <= 1'b0;
    // Watchdog always on: timeout in sleep wakes without reset
    apb(1'b1, swc_pkg::ADDR_CONTROL, 32'h0C);
    pulse_sleep;
    wait_sig(0);
    chk1(o_wdt_run, 1'b1);
    @(posedge i_core_clk) i_wdt_timeout <= 1'b1;
    @(posedge i_core_clk) i_wdt_timeout <= 1'b0;
    wait_sig(1);
    rd(swc_pkg::ADDR_STATUS, 33'h038, 33'h020);
    // Watchdog off in sleep: timeout ignored, power-on reset wakes
    apb(1'b1, swc_pkg::ADDR_CONTROL, 32'h08);
    pulse_sleep;
    wait_sig(0);
    chk1(o_wdt_run, 1'b0);
    @(posedge i_core_clk) i_wdt_timeout <= 1'b1;
    @(posedge i_core_clk) i_wdt_timeout <= 1'b0;
    repeat (4) @(posedge i_core_clk);
    chk1(o_asleep, 1'b1);
    @(posedge i_core_clk) i_rst_src.por <= 1'b1;
    @(posedge i_core_clk) i_rst_src.por <= 1'b0;
    wait_sig(4);
    repeat (2) @(posedge i_core_clk);
    chk1(o_asleep, 1'b0);
    rd(swc_pkg::ADDR_STATUS, 33'h018, 33'h018);
    // Interrupt arising just after the instruction: full entry, then wake
    apb(1'b1, swc_pkg::ADDR_CONTROL, 32'h0);
    apb(1'b1, swc_pkg::ADDR_ENABLES, 32'h10);
    @(posedge i_core_clk) i_sleep_exec <= 1'b1;
    @(posedge i_core_clk) begin
      i_sleep_exec <= 1'b0;
      i_flag_event <= 5'h02;
    end
    @(posedge i_core_clk) i_flag_event <= 5'h00;
    wait_sig(1);
    rd(swc_pkg::ADDR_STATUS, 33'h018, 33'h010);
    repeat (3) @(posedge i_core_clk);
    give_verdict;
  end
endmodule
bind swc_sleep_ctrl swc_sleep_ctrl_asserts u_swc_sleep_ctrl_asserts (.i_core_clk, .i_rst, .i_psel, .i_penable,
  .i_pwrite, .i_paddr, .i_sleep_exec, .i_wdt_timeout, .i_rst_src, .o_prdata, .o_cpu_clk_en, .o_prefetch_next,
  .o_resume, .o_irq_vector_req, .o_device_reset, .o_wdt_clear, .o_wdt_run, .o_ost_start, .o_slow_clks_en,
  .o_io_hold, .o_asleep, .o_power_down_flag_n, .o_time_out_flag_n);
